// ---- include/tofit_defines.svh ----
// Constants of the time-of-flight sensor two-wire target port.
// Assumes inclusion by bare name from the package and from the design files.
`ifndef TOFIT_DEFINES_SVH
`define TOFIT_DEFINES_SVH

// =====================================================================
// Bus address
// Eight-bit form of the target address with the direction bit clear
`define TOFIT_ADDR_WR      8'h52
// Value of the direction bit that selects a controller read
`define TOFIT_DIR_READ     1'h1

// =====================================================================
// Byte framing and index
`define TOFIT_BYTE_BITS    4'h8
`define TOFIT_IDX_RST      16'h0000
`define TOFIT_IDX_STEP     16'h0001

// =====================================================================
// Write buffer
`define TOFIT_FIFO_DEPTH   8
`define TOFIT_WR_WIDTH     24

// =====================================================================
// Timing: highest bit rate the controller may use, and the system clock
`define TOFIT_MAX_RATE_KHZ 1000
`define TOFIT_MCLK_KHZ     100000
// System clock edges per shortest bit period
`define TOFIT_BIT_CYCLES   (`TOFIT_MCLK_KHZ / `TOFIT_MAX_RATE_KHZ)

`endif

// ---- include/tofit_pkg.sv ----
// Types shared by the two-wire target port and its self-checking bench.
// Assumes tofit_defines.svh is on the include path.
`include "tofit_defines.svh"

package tofit_pkg;

  // ===================================================================
  // Protocol states, Gray coded along idle, receive, acknowledge, send
  typedef enum logic [2:0] {
    TOFIT_ST_IDLE = 3'h0,
    TOFIT_ST_RX   = 3'h1,
    TOFIT_ST_ACK  = 3'h3,
    TOFIT_ST_TX   = 3'h2,
    TOFIT_ST_MACK = 3'h6
  } tofit_state_t;

  // ===================================================================
  // Meaning of the byte being received in a message
  typedef enum logic [1:0] {
    TOFIT_ROLE_ADDR   = 2'h0,
    TOFIT_ROLE_IDX_HI = 2'h1,
    TOFIT_ROLE_IDX_LO = 2'h3,
    TOFIT_ROLE_DATA   = 2'h2
  } tofit_role_t;

  // ===================================================================
  // One register write handed to the sensor core
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  data;
  } tofit_wr_t;

endpackage

// ---- core/tofit_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset, depth a power of two.
module tofit_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // Filling side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Draining side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // =====================================================================
  // Handshakes; full and empty come straight from the occupancy count
  assign o_ready = (count_q != (AW+1)'(DEPTH));
  assign o_valid = (count_q != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem_q[rd_ptr_q];

  // Storage, written only on an accepted push
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ---- core/tofit_target.sv ----
// Two-wire target port of a multizone time-of-flight sensor.
// Assumes SCL and SDA arrive as raw pins, open-drain SDA resolved outside,
// and a sensor core that looks up o_rd_idx combinationally on i_rd_data.
`include "tofit_defines.svh"

module tofit_target (
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rst_n,
  // Interface select, high also resets the port
  input  wire logic                i_if_sel,
  // Two-wire bus pins
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output logic                     o_sda,
  output logic                     o_sda_oe,
  // Register writes to the sensor core
  output logic                     o_wr_valid,
  input  wire logic                i_wr_ready,
  output tofit_pkg::tofit_wr_t     o_wr,
  // Register reads from the sensor core
  output logic              [15:0] o_rd_idx,
  input  wire logic         [7:0]  i_rd_data
);

  localparam logic [7:0] ADDR_WR = `TOFIT_ADDR_WR;

  // Address byte decode, shared by the protocol logic and its checks
  function automatic logic addr_match(input logic [7:0] b);
    addr_match = (b[7:1] == ADDR_WR[7:1]);
  endfunction

  // =====================================================================
  // Declarations
  tofit_pkg::tofit_state_t st_q;
  tofit_pkg::tofit_role_t  role_q;
  logic [1:0]  scl_m_q;
  logic [1:0]  sda_m_q;
  logic [1:0]  sel_m_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  sr_q;
  logic [15:0] idx_q;
  logic        dir_q;
  logic        mack_q;
  logic        sda_oe_q;
  logic        sda_q;
  logic        rst_l;
  logic        scl_rise;
  logic        scl_fall;
  logic        start;
  logic        stop;
  logic        byte_end;
  logic        ack_end;
  logic        ack_ok;
  logic        load_tx;
  logic        push;
  logic        fifo_in_ready;
  logic        fifo_o_valid;
  logic        fifo_rd_ready;
  logic [23:0] fifo_o_data;
  logic        wr_valid_q;
  tofit_pkg::tofit_wr_t wr_q;

  // =====================================================================
  // Pin synchronisers; idle bus reads high so no false edge at reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      scl_m_q <= 2'h3;
      sda_m_q <= 2'h3;
      sel_m_q <= 2'h0;
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_m_q <= {scl_m_q[0], i_scl};
      sda_m_q <= {sda_m_q[0], i_sda};
      sel_m_q <= {sel_m_q[0], i_if_sel};
      scl_p_q <= scl_m_q[1];
      sda_p_q <= sda_m_q[1];
    end
  end

  // Port reset: while select is high the port is held idle
  assign rst_l = !i_rst_n || sel_m_q[1];

  // Bus events seen on the synchronised lines
  assign scl_rise = scl_m_q[1] && !scl_p_q;
  assign scl_fall = !scl_m_q[1] && scl_p_q;
  assign start    = scl_m_q[1] && scl_p_q && sda_p_q && !sda_m_q[1];
  assign stop     = scl_m_q[1] && scl_p_q && !sda_p_q && sda_m_q[1];

  // Byte framing: eighth bit sampled, now at the falling edge
  assign byte_end = scl_fall && (bit_cnt_q == `TOFIT_BYTE_BITS);
  assign ack_end  = scl_fall && (st_q == tofit_pkg::TOFIT_ST_ACK);
  // A full write buffer withholds the acknowledge, which ends the stream
  always_comb begin
    case (role_q)
      tofit_pkg::TOFIT_ROLE_ADDR: ack_ok = addr_match(sr_q);
      tofit_pkg::TOFIT_ROLE_DATA: ack_ok = fifo_in_ready;
      default:                    ack_ok = 1'b1;
    endcase
  end
  // Load the next read byte after address or controller acknowledge
  assign load_tx = (ack_end && role_q == tofit_pkg::TOFIT_ROLE_ADDR && dir_q) ||
                   (scl_fall && st_q == tofit_pkg::TOFIT_ST_MACK && !mack_q);
  assign push    = ack_end && (role_q == tofit_pkg::TOFIT_ROLE_DATA);

  // =====================================================================
  // Protocol state, byte role and bit count
  always_ff @(posedge i_mclk) begin
    if (rst_l) begin
      st_q      <= tofit_pkg::TOFIT_ST_IDLE;
      role_q    <= tofit_pkg::TOFIT_ROLE_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (start) begin
      // A repeated start restarts from the address byte
      st_q      <= tofit_pkg::TOFIT_ST_RX;
      role_q    <= tofit_pkg::TOFIT_ROLE_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (stop) begin
      st_q <= tofit_pkg::TOFIT_ST_IDLE;
    end else begin
      case (st_q)
        tofit_pkg::TOFIT_ST_RX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_end) begin
            st_q <= ack_ok ? tofit_pkg::TOFIT_ST_ACK : tofit_pkg::TOFIT_ST_IDLE;
          end
        end
        tofit_pkg::TOFIT_ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (load_tx) begin
              st_q   <= tofit_pkg::TOFIT_ST_TX;
              role_q <= tofit_pkg::TOFIT_ROLE_DATA;
            end else begin
              // Index high byte, then low byte, then data
              st_q <= tofit_pkg::TOFIT_ST_RX;
              case (role_q)
                tofit_pkg::TOFIT_ROLE_ADDR:   role_q <= tofit_pkg::TOFIT_ROLE_IDX_HI;
                tofit_pkg::TOFIT_ROLE_IDX_HI: role_q <= tofit_pkg::TOFIT_ROLE_IDX_LO;
                default:                      role_q <= tofit_pkg::TOFIT_ROLE_DATA;
              endcase
            end
          end
        end
        tofit_pkg::TOFIT_ST_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_end) begin
            st_q <= tofit_pkg::TOFIT_ST_MACK;
          end
        end
        tofit_pkg::TOFIT_ST_MACK: begin
          if (scl_fall) begin
            // Controller not-acknowledge ends the read
            st_q      <= load_tx ? tofit_pkg::TOFIT_ST_TX : tofit_pkg::TOFIT_ST_IDLE;
            bit_cnt_q <= 4'h0;
          end
        end
        default: st_q <= tofit_pkg::TOFIT_ST_IDLE;
      endcase
    end
  end

  // Direction bit of the address byte, kept for the whole message
  always_ff @(posedge i_mclk) begin
    if (rst_l) begin
      dir_q <= 1'b0;
    end else if (byte_end && st_q == tofit_pkg::TOFIT_ST_RX && role_q == tofit_pkg::TOFIT_ROLE_ADDR) begin
      dir_q <= (sr_q[0] == `TOFIT_DIR_READ);
    end
  end

  // Controller acknowledge, sampled in its slot
  always_ff @(posedge i_mclk) begin
    if (rst_l) begin
      mack_q <= 1'b1;
    end else if (scl_rise && st_q == tofit_pkg::TOFIT_ST_MACK) begin
      mack_q <= sda_m_q[1];
    end
  end

  // =====================================================================
  // Serial/parallel register: shift in on rise, load and shift out on fall
  always_ff @(posedge i_mclk) begin
    if (rst_l || start) begin
      sr_q <= 8'h00;
    end else if (scl_rise && st_q == tofit_pkg::TOFIT_ST_RX) begin
      sr_q <= {sr_q[6:0], sda_m_q[1]};
    end else if (load_tx) begin
      sr_q <= i_rd_data;
    end else if (scl_fall && st_q == tofit_pkg::TOFIT_ST_TX && !byte_end) begin
      sr_q <= {sr_q[6:0], 1'b0};
    end
  end

  // Register index: loaded high byte first, advanced after each acknowledged write byte and each read byte
  always_ff @(posedge i_mclk) begin
    if (rst_l) begin
      idx_q <= `TOFIT_IDX_RST;
    end else if (ack_end && role_q == tofit_pkg::TOFIT_ROLE_IDX_HI) begin
      idx_q[15:8] <= sr_q;
    end else if (ack_end && role_q == tofit_pkg::TOFIT_ROLE_IDX_LO) begin
      idx_q[7:0] <= sr_q;
    end else if (push || (byte_end && st_q == tofit_pkg::TOFIT_ST_TX)) begin
      idx_q <= idx_q + `TOFIT_IDX_STEP;
    end
  end

  // =====================================================================
  // SDA drive: only ever pulled low, changed just after SCL falls, cleared at once by start, stop or port reset
  always_ff @(posedge i_mclk) begin
    if (rst_l || start || stop) begin
      sda_oe_q <= 1'b0;
    end else if (byte_end && st_q == tofit_pkg::TOFIT_ST_RX) begin
      sda_oe_q <= ack_ok;
    end else if (load_tx) begin
      sda_oe_q <= !i_rd_data[7];
    end else if (scl_fall && st_q == tofit_pkg::TOFIT_ST_TX) begin
      sda_oe_q <= byte_end ? 1'b0 : !sr_q[6];
    end else if (scl_fall) begin
      sda_oe_q <= 1'b0;
    end
  end

  // Driven level is always low; the pull-up makes the high
  always_ff @(posedge i_mclk) begin
    sda_q <= 1'b0;
  end

  // =====================================================================
  // Write buffer; data is stored once its acknowledge slot ends
  tofit_fifo #(
    .WIDTH (`TOFIT_WR_WIDTH),
    .DEPTH (`TOFIT_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_valid (push),
    .o_ready (fifo_in_ready),
    .i_data  ({idx_q, sr_q}),
    .o_valid (fifo_o_valid),
    .i_ready (fifo_rd_ready),
    .o_data  (fifo_o_data)
  );

  // Output stage keeps the core-facing write port on flip-flops
  assign fifo_rd_ready = !wr_valid_q || i_wr_ready;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_valid_q <= 1'b0;
      wr_q       <= '0;
    end else if (fifo_rd_ready) begin
      wr_valid_q <= fifo_o_valid;
      if (fifo_o_valid) begin
        wr_q <= fifo_o_data;
      end
    end
  end

  assign o_sda      = sda_q;
  assign o_sda_oe   = sda_oe_q;
  assign o_wr_valid = wr_valid_q;
  assign o_wr       = wr_q;
  assign o_rd_idx   = idx_q;

  // =====================================================================
  // Checks
  default clocking dc @(posedge i_mclk); endclocking
  default disable iff (rst_l);

  sequence addr_byte_s;
    byte_end && st_q == tofit_pkg::TOFIT_ST_RX && role_q == tofit_pkg::TOFIT_ROLE_ADDR;
  endsequence
  sequence data_ack_end_s;
    ack_end && role_q == tofit_pkg::TOFIT_ROLE_DATA && !start && !stop;
  endsequence

  addr_ack_a: assert property (addr_byte_s and (addr_match(sr_q) && !start && !stop)
    |=> o_sda_oe && st_q == tofit_pkg::TOFIT_ST_ACK) else $error("address not acknowledged");
  addr_miss_a: assert property (addr_byte_s and (!addr_match(sr_q) && !start && !stop)
    |=> !o_sda_oe && st_q == tofit_pkg::TOFIT_ST_IDLE) else $error("foreign address answered");
  dir_latch_a: assert property (addr_byte_s |=> dir_q == $past(sr_q[0]))
    else $error("direction bit not latched");
  start_det_a: assert property (start |=> st_q == tofit_pkg::TOFIT_ST_RX && bit_cnt_q == 4'h0
    && role_q == tofit_pkg::TOFIT_ROLE_ADDR && !o_sda_oe) else $error("start not taken");
  stop_det_a: assert property (stop |=> st_q == tofit_pkg::TOFIT_ST_IDLE && !o_sda_oe)
    else $error("stop not taken");
  rise_sample_a: assert property (scl_rise && st_q == tofit_pkg::TOFIT_ST_RX && !start && !stop
    |=> sr_q[0] == $past(sda_m_q[1])) else $error("bit not sampled on rise");
  sda_change_a: assert property ($changed(o_sda_oe) |-> $past(scl_fall || start || stop))
    else $error("SDA drive changed outside SCL low");
  idx_step_a: assert property (data_ack_end_s |=> idx_q == $past(idx_q) + `TOFIT_IDX_STEP)
    else $error("index not advanced");
  full_nack_a: assert property (byte_end && st_q == tofit_pkg::TOFIT_ST_RX && !fifo_in_ready
    && role_q == tofit_pkg::TOFIT_ROLE_DATA |=> !o_sda_oe) else $error("write acknowledged while full");

endmodule

// ---- tb/tofit_host.sv ----
// Behavioural two-wire bus controller facing the target port.
// Assumes the bench resolves SDA from both pulls; SDA and SCL have pull-ups.
module tofit_host (
  // Clock
  input  wire logic i_mclk,
  // Bus
  output logic      o_scl,
  output logic      o_sda_pull,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Timing
  // Quarter bit of 25 mclk: 1 us per bit, the top rate allowed
  localparam int H = 25;

  // Lines start released, so the idle bus floats high
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // =====================================================================
  // Bus conditions
  // SCL low, SDA pull to a, SCL high, then SDA pull to b while SCL is high
  task automatic cond(input logic a, input logic b);
    o_scl <= 1'b0;
    tick(H);
    o_sda_pull <= a;
    tick(H);
    o_scl <= 1'b1;
    tick(2 * H);
    o_sda_pull <= b;
    tick(2 * H);
  endtask

  // Start and repeated start; the controller opens every message
  task automatic start();
    cond(1'b0, 1'b1);
  endtask

  // Only the controller closes a message
  task automatic stop();
    cond(1'b1, 1'b0);
  endtask

  // =====================================================================
  // Bits and bytes
  // SDA moves mid low phase only, so it is steady while SCL is high
  task automatic xfer_bit(input logic b, output logic r);
    o_scl <= 1'b0;
    tick(H);
    o_sda_pull <= ~b;
    tick(H);
    o_scl <= 1'b1;
    tick(2 * H);
    r = i_sda;
  endtask

  // Eight bits MSB first, then the acknowledge slot released
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  // Byte read; low acknowledges, high ends the read
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(nack, r);
  endtask
endmodule

// ---- tb/tofit_target_test.sv ----
// Self-checking bench for the two-wire target port.
// Assumes tofit_host as bus controller and a sensor core modelled here.
module tofit_target_test;
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Signals
  logic                 mclk     = 1'b0;
  logic                 rst_n    = 1'b0;
  logic                 if_sel   = 1'b0;
  logic                 wr_ready = 1'b1;
  logic                 scl;
  logic                 sda;
  logic                 sda_pull;
  logic                 sda_o;
  logic                 sda_oe;
  logic                 wr_valid;
  tofit_pkg::tofit_wr_t wr;
  logic          [15:0] rd_idx;
  logic          [7:0]  rd_data;
  tofit_pkg::tofit_wr_t got_q[$];
  int                   num_errors = 0;
  int                   n_checks   = 0;
  int                   cycles     = 0;

  // Core register contents: a pattern that differs from one index to the next, except 7FFF to 8000 and FFFF to 0000
  function automatic logic [7:0] reg_val(input logic [15:0] idx);
    return idx[7:0] ^ idx[15:8] ^ 8'h5A;
  endfunction

  // Open-drain SDA: low if either party pulls, pull-up otherwise
  assign sda     = ~(sda_oe | sda_pull);
  assign rd_data = reg_val(rd_idx);

  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  tofit_target dut_u (
    .i_mclk     (mclk),
    .i_rst_n    (rst_n),
    .i_if_sel   (if_sel),
    .i_scl      (scl),
    .i_sda      (sda),
    .o_sda      (sda_o),
    .o_sda_oe   (sda_oe),
    .o_wr_valid (wr_valid),
    .i_wr_ready (wr_ready),
    .o_wr       (wr),
    .o_rd_idx   (rd_idx),
    .i_rd_data  (rd_data)
  );

  tofit_host host_u (
    .i_mclk     (mclk),
    .o_scl      (scl),
    .o_sda_pull (sda_pull),
    .i_sda      (sda)
  );

  // Records taken by the core, in order
  always @(posedge mclk) begin
    if (rst_n && wr_valid === 1'b1 && wr_ready) begin
      got_q.push_back(wr);
    end
  end

  // Hang guard: about 40k cycles are expected
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      conclude();
    end
  end

  // =====================================================================
  // Compare helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rec(input logic [15:0] idx, input logic [7:0] d);
    tofit_pkg::tofit_wr_t r;
    r = '0;
    if (got_q.size() > 0) begin
      r = got_q.pop_front();
    end
    chk(r, {idx, d}, "record");
  endtask

  // Start, write address, index MSB then LSB, each acknowledged
  task automatic wr_idx(input logic [15:0] idx);
    logic ack;
    host_u.start();
    host_u.send(8'h52, ack);
    chk(24'(ack), 24'h1, "addr ack");
    host_u.send(idx[15:8], ack);
    chk(24'(ack), 24'h1, "idx hi ack");
    host_u.send(idx[7:0], ack);
    chk(24'(ack), 24'h1, "idx lo ack");
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_addr();
    logic [7:0] a[4];
    logic       ack;
    a = '{8'h52, 8'h50, 8'h12, 8'hD2};
    for (int i = 0; i < 4; i++) begin
      host_u.start();
      host_u.send(a[i], ack);
      chk(24'(ack), 24'(i == 0), "addr match");
      host_u.stop();
      chk(24'({sda_oe, sda}), 24'h1, "idle bus");
    end
    chk(24'(got_q.size()), 24'h0, "no record");
    $display("t_addr done");
  endtask

  task automatic t_write();
    logic ack;
    wr_idx(16'h12FF);
    for (int k = 0; k < 3; k++) begin
      host_u.send(8'hC0 + 8'(k), ack);
      chk(24'(ack), 24'h1, "data ack");
    end
    host_u.stop();
    for (int k = 0; k < 3; k++) begin
      chk_rec(16'h12FF + 16'(k), 8'hC0 + 8'(k));
    end
    chk(24'(rd_idx), 24'h001302, "index");
    $display("t_write done");
  endtask

  task automatic t_read();
    logic       ack;
    logic [7:0] d;
    wr_idx(16'h00FE);
    host_u.start();
    host_u.send(8'h53, ack);
    chk(24'(ack), 24'h1, "read addr ack");
    for (int k = 0; k < 3; k++) begin
      host_u.recv(k == 2, d);
      chk(24'(d), 24'(reg_val(16'h00FE + 16'(k))), "read data");
    end
    chk(24'(sda_oe), 24'h0, "released after nack");
    host_u.stop();
    chk(24'(rd_idx), 24'h000101, "index");
    chk(24'(got_q.size()), 24'h0, "read writes nothing");
    $display("t_read done");
  endtask

  task automatic t_full();
    logic ack;
    wr_ready <= 1'b0;
    wr_idx(16'h0200);
    for (int k = 0; k < 10; k++) begin
      host_u.send(8'h30 + 8'(k), ack);
      chk(24'(ack), 24'(k < 9), "full refusal");
    end
    host_u.stop();
    chk(24'(rd_idx), 24'h000209, "index held");
    chk(24'(wr_valid), 24'h1, "valid held");
    wr_ready <= 1'b1;
    repeat (30) @(posedge mclk);
    for (int k = 0; k < 9; k++) begin
      chk_rec(16'h0200 + 16'(k), 8'h30 + 8'(k));
    end
    chk(24'(wr_valid), 24'h0, "drained");
    $display("t_full done");
  endtask

  // Port reset mid-message: the held record must survive, the cut byte is lost
  task automatic t_sel();
    logic ack;
    wr_ready <= 1'b0;
    wr_idx(16'h0345);
    for (int k = 0; k < 2; k++) begin
      host_u.send(8'h66 + 8'(k), ack);
      chk(24'(ack), 24'h1, "sel data ack");
    end
    @(posedge mclk);
    if_sel <= 1'b1;
    repeat (6) @(posedge mclk);
    if_sel <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(24'(rd_idx), 24'h0, "index reset");
    chk(24'(sda_oe), 24'h0, "drive reset");
    chk(24'(wr_valid), 24'h1, "record kept");
    wr_ready <= 1'b1;
    host_u.stop();
    wr_idx(16'h0010);
    host_u.send(8'h77, ack);
    chk(24'(ack), 24'h1, "data ack");
    host_u.stop();
    chk_rec(16'h0345, 8'h66);
    chk_rec(16'h0010, 8'h77);
    $display("t_sel done");
  endtask

  // =====================================================================
  // Run
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Select is low, except for the pulse in t_sel, so this port is the one in use
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(24'({sda_oe, sda_o, wr_valid}), 24'h0, "reset outputs");
    chk(24'(rd_idx), 24'h0, "reset index");
    t_addr();
    t_write();
    t_read();
    t_full();
    t_sel();
    conclude();
  end
endmodule
